// >>> hw/mfd_config.sv
// mosfet fault detector configuration bank and detection gating
// assumes an spi front end that presents decoded byte address, data
// and one-cycle write and read strobes on the core clock
//
// Notes on behaviour
// - bits 13:12 choose low-side drain filter time 6, 8, 10, 12 us.
// - bits 11:8 hold U low-side drain threshold, codes 0 to B.
// - bits 7:4 hold V low-side drain threshold, same coding.
// - bits 3:0 hold W low-side drain threshold, same coding.
// - unlisted codes leave that field at its previous value.
// - threshold register written at 2Ch, read back at ACh.
// - disable mask written at 30h, read back at B0h.
// - mask bit 0 runs detector; 1 blanks its detection, including one already present.
// - U phase mask bits 11..8: hs gs, hs ds, ls gs, ls ds.
// - V phase mask bits 7..4: hs gs, hs ds, ls gs, ls ds.
// - W phase mask bits 3..0: hs gs, hs ds, ls gs, ls ds.
`timescale 1ns/100ps
module mfd_config
  import mfd_pkg::*;
(
  // clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 rst_n_in,
  // register access from spi
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic [15:0]          reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic      [15:0]          reg_rdata_out,
  output logic                      reg_rvalid_out,
  // analog settings
  output logic      [1:0]           ls_filter_sel_out,
  output logic      [3:0]           ls_vth_u_out,
  output logic      [3:0]           ls_vth_v_out,
  output logic      [3:0]           ls_vth_w_out,
  output logic      [DET_COUNT-1:0] det_disable_out,
  // comparators in, detections out
  input  wire logic [DET_COUNT-1:0] cmp_raw_in,
  output logic      [DET_COUNT-1:0] det_out
);

  // register storage
  logic [15:0]          thr_reg;
  logic [15:0]          mask_reg;
  logic [15:0]          next_thr;
  logic [15:0]          next_mask;
  logic [15:0]          next_rdata;
  logic                 next_rvalid;
  logic [DET_COUNT-1:0] next_det;

  // decode
  wire thr_wr  = reg_wr_in & (reg_addr_in == ADDR_THR_WR);
  wire mask_wr = reg_wr_in & (reg_addr_in == ADDR_MASK_WR);
  wire thr_rd  = reg_addr_in == ADDR_THR_RD;
  wire mask_rd = reg_addr_in == ADDR_MASK_RD;

  // field candidates from the write data
  wire [1:0] wr_fil  = reg_wdata_in[FIL_MSB:FIL_LSB];
  wire [3:0] wr_vthu = reg_wdata_in[VTHU_MSB:VTHU_LSB];
  wire [3:0] wr_vthv = reg_wdata_in[VTHV_MSB:VTHV_LSB];
  wire [3:0] wr_vthw = reg_wdata_in[VTHW_MSB:VTHW_LSB];

  // stored fields
  wire [1:0] cur_fil  = thr_reg[FIL_MSB:FIL_LSB];
  wire [3:0] cur_vthu = thr_reg[VTHU_MSB:VTHU_LSB];
  wire [3:0] cur_vthv = thr_reg[VTHV_MSB:VTHV_LSB];
  wire [3:0] cur_vthw = thr_reg[VTHW_MSB:VTHW_LSB];

  // per-field update, unlisted codes keep the old value
  wire [1:0] upd_fil  = wr_fil;
  wire [3:0] upd_vthu = mfd_vth_ok(wr_vthu) ? wr_vthu : cur_vthu;
  wire [3:0] upd_vthv = mfd_vth_ok(wr_vthv) ? wr_vthv : cur_vthv;
  wire [3:0] upd_vthw = mfd_vth_ok(wr_vthw) ? wr_vthw : cur_vthw;

  // unused bits stay zero
  wire [15:0] thr_wr_val  = {2'h0, upd_fil, upd_vthu, upd_vthv, upd_vthw}
                            & THR_USED;
  wire [15:0] mask_wr_val = reg_wdata_in & MASK_USED;

  assign next_thr  = thr_wr  ? thr_wr_val  : thr_reg;
  assign next_mask = mask_wr ? mask_wr_val : mask_reg;

  // read mux; other addresses answer zero
  assign next_rdata  = !reg_rd_in ? reg_rdata_out :
                       thr_rd     ? (thr_reg & THR_USED) :
                       mask_rd    ? (mask_reg & MASK_USED) :
                       16'h0000;
  assign next_rvalid = reg_rd_in;

  // filter length from the selected code
  logic [FIL_CNT_W-1:0] fil_limit;
  always_comb begin
    case (cur_fil)
      FIL_CODE_6US:  fil_limit = FIL_6US_CYC;
      FIL_CODE_8US:  fil_limit = FIL_8US_CYC;
      FIL_CODE_10US: fil_limit = FIL_10US_CYC;
      FIL_CODE_12US: fil_limit = FIL_12US_CYC;
      default:       fil_limit = FIL_12US_CYC;
    endcase
  end

  // synchronised and gated comparators
  logic [DET_COUNT-1:0] cond_sync;
  logic [DET_COUNT-1:0] cond_active;

  mfd_sync_gate u_sync_gate (
    .clk_in     (mclk_in),
    .rst_n_in   (rst_n_in),
    .raw_in     (cmp_raw_in),
    .disable_in (mask_reg[DET_COUNT-1:0]),
    .cond_out   (cond_sync),
    .active_out (cond_active)
  );

  // low-side drain detectors get the persistence filter
  logic fault_ls_u;
  logic fault_ls_v;
  logic fault_ls_w;

  mfd_vds_filter u_filter_u (
    .clk_in    (mclk_in),
    .rst_n_in  (rst_n_in),
    .cond_in   (cond_sync[DIS_LS_DS_U]),
    .enable_in (~mask_reg[DIS_LS_DS_U]),
    .limit_in  (fil_limit),
    .fault_out (fault_ls_u)
  );

  mfd_vds_filter u_filter_v (
    .clk_in    (mclk_in),
    .rst_n_in  (rst_n_in),
    .cond_in   (cond_sync[DIS_LS_DS_V]),
    .enable_in (~mask_reg[DIS_LS_DS_V]),
    .limit_in  (fil_limit),
    .fault_out (fault_ls_v)
  );

  mfd_vds_filter u_filter_w (
    .clk_in    (mclk_in),
    .rst_n_in  (rst_n_in),
    .cond_in   (cond_sync[DIS_LS_DS_W]),
    .enable_in (~mask_reg[DIS_LS_DS_W]),
    .limit_in  (fil_limit),
    .fault_out (fault_ls_w)
  );

  // detection vector, one bit per detector in mask order
  always_comb begin
    next_det              = cond_active;
    next_det[DIS_LS_DS_U] = fault_ls_u;
    next_det[DIS_LS_DS_V] = fault_ls_v;
    next_det[DIS_LS_DS_W] = fault_ls_w;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      thr_reg        <= THR_RESET;
      mask_reg       <= MASK_RESET;
      reg_rdata_out  <= 16'h0000;
      reg_rvalid_out <= 1'b0;
      det_out        <= '0;
    end else begin
      thr_reg        <= next_thr;
      mask_reg       <= next_mask;
      reg_rdata_out  <= next_rdata;
      reg_rvalid_out <= next_rvalid;
      det_out        <= next_det;
    end
  end

  // settings to the analog side, straight from the registers
  assign ls_filter_sel_out = thr_reg[FIL_MSB:FIL_LSB];
  assign ls_vth_u_out      = thr_reg[VTHU_MSB:VTHU_LSB];
  assign ls_vth_v_out      = thr_reg[VTHV_MSB:VTHV_LSB];
  assign ls_vth_w_out      = thr_reg[VTHW_MSB:VTHW_LSB];
  assign det_disable_out   = mask_reg[DET_COUNT-1:0];

endmodule

// >>> hw/mfd_pkg.sv
// package for the mosfet fault detector configuration bank
// assumes a 40 MHz core clock and a byte-wide register address from spi
package mfd_pkg;

  // register addresses, write and read addresses differ
  localparam logic [7:0]  ADDR_THR_WR   = 8'h2C;
  localparam logic [7:0]  ADDR_THR_RD   = 8'hAC;
  localparam logic [7:0]  ADDR_MASK_WR  = 8'h30;
  localparam logic [7:0]  ADDR_MASK_RD  = 8'hB0;

  // reset values
  localparam logic [15:0] THR_RESET     = 16'h0444;
  localparam logic [15:0] MASK_RESET    = 16'h0000;

  // implemented bits; the rest read zero
  localparam logic [15:0] THR_USED      = 16'h3FFF;
  localparam logic [15:0] MASK_USED     = 16'h0FFF;

  // threshold register fields
  localparam int          FIL_MSB       = 13;
  localparam int          FIL_LSB       = 12;
  localparam int          VTHU_MSB      = 11;
  localparam int          VTHU_LSB      = 8;
  localparam int          VTHV_MSB      = 7;
  localparam int          VTHV_LSB      = 4;
  localparam int          VTHW_MSB      = 3;
  localparam int          VTHW_LSB      = 0;
  localparam logic [3:0]  VTH_MAX       = 4'hB;

  // filter codes
  localparam logic [1:0]  FIL_CODE_6US  = 2'h0;
  localparam logic [1:0]  FIL_CODE_8US  = 2'h1;
  localparam logic [1:0]  FIL_CODE_10US = 2'h2;
  localparam logic [1:0]  FIL_CODE_12US = 2'h3;

  // detector mask bit positions, per phase
  localparam int          DET_COUNT     = 12;
  localparam int          DIS_HS_GS_U   = 11;
  localparam int          DIS_HS_DS_U   = 10;
  localparam int          DIS_LS_GS_U   = 9;
  localparam int          DIS_LS_DS_U   = 8;
  localparam int          DIS_HS_GS_V   = 7;
  localparam int          DIS_HS_DS_V   = 6;
  localparam int          DIS_LS_GS_V   = 5;
  localparam int          DIS_LS_DS_V   = 4;
  localparam int          DIS_HS_GS_W   = 3;
  localparam int          DIS_HS_DS_W   = 2;
  localparam int          DIS_LS_GS_W   = 1;
  localparam int          DIS_LS_DS_W   = 0;

  // filter timing
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          FIL_6US_NS    = 6000;
  localparam int          FIL_8US_NS    = 8000;
  localparam int          FIL_10US_NS   = 10000;
  localparam int          FIL_12US_NS   = 12000;
  localparam int          FIL_CNT_W     = 9;
  localparam logic [FIL_CNT_W-1:0] FIL_6US_CYC =
    FIL_CNT_W'((FIL_6US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [FIL_CNT_W-1:0] FIL_8US_CYC =
    FIL_CNT_W'((FIL_8US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [FIL_CNT_W-1:0] FIL_10US_CYC =
    FIL_CNT_W'((FIL_10US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [FIL_CNT_W-1:0] FIL_12US_CYC =
    FIL_CNT_W'((FIL_12US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [FIL_CNT_W-1:0] FIL_CNT_ONE = 9'h001;
  localparam logic [FIL_CNT_W-1:0] FIL_CNT_ZERO = 9'h000;

  // filter states
  typedef enum logic [1:0] {
    MFD_FLT_IDLE  = 2'b00,
    MFD_FLT_COUNT = 2'b01,
    MFD_FLT_FAULT = 2'b10
  } mfd_flt_state_t;

  // threshold code is one of the listed values
  function automatic logic mfd_vth_ok(input logic [3:0] code);
    return code <= VTH_MAX;
  endfunction

endpackage

// >>> hw/mfd_sync_gate.sv
// two-flop synchroniser and disable gate for the twelve comparators
// assumes comparator levels arrive asynchronously from the analog side
`timescale 1ns/100ps
module mfd_sync_gate
  import mfd_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  // comparators and mask
  input  wire logic [DET_COUNT-1:0] raw_in,
  input  wire logic [DET_COUNT-1:0] disable_in,
  // synchronised condition and gated detections
  output logic      [DET_COUNT-1:0] cond_out,
  output logic      [DET_COUNT-1:0] active_out
);

  logic [DET_COUNT-1:0] meta;
  logic [DET_COUNT-1:0] stable;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta   <= '0;
      stable <= '0;
    end else begin
      meta   <= raw_in;
      stable <= meta;
    end
  end

  assign cond_out   = stable;
  // a disabled detector reports nothing, not even a detection already present
  assign active_out = stable & ~disable_in;

endmodule

// >>> hw/mfd_vds_filter.sv
// persistence filter for one low-side drain-source comparator
// assumes a synchronised condition and a stable filter length
`timescale 1ns/100ps
module mfd_vds_filter
  import mfd_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  // condition and control
  input  wire logic                 cond_in,
  input  wire logic                 enable_in,
  input  wire logic [FIL_CNT_W-1:0] limit_in,
  // filtered fault level
  output logic                      fault_out
);

  mfd_flt_state_t         state;
  mfd_flt_state_t         next_state;
  logic [FIL_CNT_W-1:0]   cnt;
  logic [FIL_CNT_W-1:0]   next_cnt;
  wire                    live = cond_in & enable_in;
  wire                    done = (cnt + FIL_CNT_ONE) >= limit_in;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      MFD_FLT_IDLE: begin
        next_cnt = FIL_CNT_ZERO;
        if (live) begin
          next_state = MFD_FLT_COUNT;
          next_cnt   = FIL_CNT_ONE;
        end
      end
      MFD_FLT_COUNT: begin
        if (!live) begin
          // short excursion is dropped
          next_state = MFD_FLT_IDLE;
          next_cnt   = FIL_CNT_ZERO;
        end else if (done) begin
          next_state = MFD_FLT_FAULT;
        end else begin
          next_cnt = cnt + FIL_CNT_ONE;
        end
      end
      MFD_FLT_FAULT: begin
        if (!live) begin
          next_state = MFD_FLT_IDLE;
          next_cnt   = FIL_CNT_ZERO;
        end
      end
      default: begin
        next_state = MFD_FLT_IDLE;
        next_cnt   = FIL_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= MFD_FLT_IDLE;
      cnt   <= FIL_CNT_ZERO;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign fault_out = (state == MFD_FLT_FAULT);

endmodule

// >>> testbench/mfd_config_properties.sv
// assertions on the fault detector configuration bank
// bound to mfd_config; one clock, synchronous reset
`timescale 1ns/100ps
module mfd_config_props
  import mfd_pkg::*;
(
  // clock, reset, register access
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        reg_rvalid_out,
  // settings and detections
  input wire logic [1:0]  ls_filter_sel_out,
  input wire logic [3:0]  ls_vth_u_out,
  input wire logic [3:0]  ls_vth_v_out,
  input wire logic [3:0]  ls_vth_w_out,
  input wire logic [11:0] det_disable_out,
  input wire logic [11:0] cmp_raw_in,
  input wire logic [11:0] det_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  function automatic logic [3:0] pick(input logic [3:0] n,
                                      input logic [3:0] o);
    return (n > VTH_MAX) ? o : n;
  endfunction
  // filter length in cycles for a filter code
  function automatic logic [FIL_CNT_W-1:0] fil_cyc(input logic [1:0] c);
    case (c)
      FIL_CODE_6US:  return FIL_6US_CYC;
      FIL_CODE_8US:  return FIL_8US_CYC;
      FIL_CODE_10US: return FIL_10US_CYC;
      default:       return FIL_12US_CYC;
    endcase
  endfunction
  logic [8:0]        hold;
  logic [8:0]        next_hold;
  wire logic         wr_thr = reg_wr_in && reg_addr_in == ADDR_THR_WR;
  wire logic         wr_msk = reg_wr_in && reg_addr_in == ADDR_MASK_WR;
  wire logic         rd_thr = reg_rd_in && reg_addr_in == ADDR_THR_RD;
  wire logic         rd_msk = reg_rd_in && reg_addr_in == ADDR_MASK_RD;
  wire logic [15:0]  cfg_thr = {2'h0, ls_filter_sel_out, ls_vth_u_out,
                                ls_vth_v_out, ls_vth_w_out};
  wire logic [11:0]  thr_next = {pick(reg_wdata_in[11:8], ls_vth_u_out),
                                 pick(reg_wdata_in[7:4], ls_vth_v_out),
                                 pick(reg_wdata_in[3:0], ls_vth_w_out)};
  // cycles the U low-side drain comparator has stayed armed
  assign next_hold = (!cmp_raw_in[8] || det_disable_out[8]) ? 9'h000 :
                     hold + {8'h00, hold != 9'h1FF};
  always_ff @(posedge mclk_in) hold <= rst_n_in ? next_hold : 9'h000;
  a_read_valid: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  a_thr_read: assert property (rd_thr |=>
    reg_rdata_out == $past(cfg_thr)) else $error("bad threshold readback");
  a_mask_read: assert property (rd_msk |=>
    reg_rdata_out == $past({4'h0, det_disable_out}))
    else $error("bad mask readback");
  a_other_read: assert property (reg_rd_in && !rd_thr && !rd_msk |=>
    reg_rdata_out == 16'h0000) else $error("unmapped read not zero");
  a_thr_write: assert property (wr_thr |=>
    cfg_thr == $past({2'h0, reg_wdata_in[13:12], thr_next}))
    else $error("bad threshold write");
  a_mask_write: assert property (wr_msk |=>
    det_disable_out == $past(reg_wdata_in[11:0])) else $error("bad mask write");
  a_cfg_hold: assert property (!wr_thr && !wr_msk |=>
    $stable({cfg_thr, det_disable_out})) else $error("setting changed");
  a_mask_blocks: assert property ((det_out & det_disable_out &
    $past(det_disable_out) & $past(det_disable_out, 2) &
    $past(det_disable_out, 3)) == 12'h000) else $error("masked detection");
  a_filter_early: assert property ($rose(det_out[8]) |->
    hold > fil_cyc($past(ls_filter_sel_out, 2)))
    else $error("filter too short");
  a_filter_late: assert property (hold >= 9'h1EA |-> det_out[8])
    else $error("filter too long");
endmodule
bind mfd_config mfd_config_props u_props (
  .mclk_in           (mclk_in),
  .rst_n_in          (rst_n_in),
  .reg_addr_in       (reg_addr_in),
  .reg_wdata_in      (reg_wdata_in),
  .reg_wr_in         (reg_wr_in),
  .reg_rd_in         (reg_rd_in),
  .reg_rdata_out     (reg_rdata_out),
  .reg_rvalid_out    (reg_rvalid_out),
  .ls_filter_sel_out (ls_filter_sel_out),
  .ls_vth_u_out      (ls_vth_u_out),
  .ls_vth_v_out      (ls_vth_v_out),
  .ls_vth_w_out      (ls_vth_w_out),
  .det_disable_out   (det_disable_out),
  .cmp_raw_in        (cmp_raw_in),
  .det_out           (det_out)
);

// >>> testbench/mfd_host_model.sv
// host model issuing register strobes on the core clock
// callers enter just after a rising edge; read answer one cycle later
`timescale 1ns/100ps
module mfd_host_model (
  // clock and answers
  input  wire logic        mclk_in,
  input  wire logic [15:0] reg_rdata_in,
  input  wire logic        reg_rvalid_in,
  // requests
  output logic      [7:0]  reg_addr_out,
  output logic      [15:0] reg_wdata_out,
  output logic             reg_wr_out,
  output logic             reg_rd_out
);
  initial begin
    reg_addr_out  = 8'h00;
    reg_wdata_out = 16'h0000;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    reg_addr_out  = a;
    reg_wdata_out = d;
    reg_wr_out    = 1'b1;
    @(posedge mclk_in);
    #1;
    reg_wr_out = 1'b0;
    // one idle edge so the next strobe is a fresh pulse
    @(posedge mclk_in);
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] q,
                        output logic v);
    reg_addr_out  = a;
    // stale write data is not held
    reg_wdata_out = ~reg_wdata_out;
    reg_rd_out    = 1'b1;
    @(posedge mclk_in);
    #1;
    reg_rd_out = 1'b0;
    q = reg_rdata_in;
    v = reg_rvalid_in;
    @(posedge mclk_in);
    #1;
  endtask
endmodule

// >>> testbench/test_mosfet_fault_detect_config.sv
// top bench for the fault detector configuration bank
// host model drives the register strobes, bench drives comparators
`timescale 1ns/100ps
module test_mosfet_fault_detect_config;
  import mfd_pkg::*;
  logic        mclk_in, rst_n_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
  logic [7:0]  reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out, exp_thr, d;
  logic [1:0]  ls_filter_sel_out;
  logic [3:0]  ls_vth_u_out, ls_vth_v_out, ls_vth_w_out;
  logic [11:0] cmp_raw_in, det_disable_out, det_out;
  int          fails, n_checks;
  mfd_config uut (
    .mclk_in           (mclk_in),
    .rst_n_in          (rst_n_in),
    .reg_addr_in       (reg_addr_in),
    .reg_wdata_in      (reg_wdata_in),
    .reg_wr_in         (reg_wr_in),
    .reg_rd_in         (reg_rd_in),
    .reg_rdata_out     (reg_rdata_out),
    .reg_rvalid_out    (reg_rvalid_out),
    .ls_filter_sel_out (ls_filter_sel_out),
    .ls_vth_u_out      (ls_vth_u_out),
    .ls_vth_v_out      (ls_vth_v_out),
    .ls_vth_w_out      (ls_vth_w_out),
    .det_disable_out   (det_disable_out),
    .cmp_raw_in        (cmp_raw_in),
    .det_out           (det_out)
  );
  mfd_host_model host (.mclk_in(mclk_in), .reg_rdata_in(reg_rdata_out),
    .reg_rvalid_in(reg_rvalid_out), .reg_addr_out(reg_addr_in),
    .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in),
    .reg_rd_out(reg_rd_in));
  task check(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want) begin
      fails++;
      $display("Error at %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task complete_run;
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] want);
    logic [15:0] q;
    logic        v;
    host.rd_reg(a, q, v);
    check({15'h0, v}, 16'h0001);
    check(q, want);
  endtask
  task automatic filt(input logic [1:0] c);
    int n;
    int k;
    n = 240 + 80 * int'(c);
    host.wr_reg(ADDR_THR_WR, {2'h0, c, 12'h444});
    cmp_raw_in = 12'h111;
    tick(n - 10);
    cmp_raw_in = 12'h000;
    tick(8);
    check({4'h0, det_out}, 16'h0000);
    cmp_raw_in = 12'h111;
    k = 0;
    while (det_out[8] !== 1'b1 && k < 600) begin
      tick(1);
      k++;
    end
    if (k >= 600) fails++;
    check({15'h0, k >= n + 1 && k <= n + 5}, 16'h0001);
    check({4'h0, det_out}, 16'h0111);
    tick(8);
    cmp_raw_in = 12'h000;
    tick(8);
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  initial begin
    rst_n_in   = 1'b0;
    cmp_raw_in = 12'h000;
    fails      = 0;
    n_checks   = 0;
    exp_thr    = 16'h0444;
    tick(10);
    rst_n_in = 1'b1;
    rd_chk(ADDR_THR_RD, 16'h0444);
    rd_chk(ADDR_MASK_RD, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      d = {2'h3, 2'(i), 4'(i), 4'(15 - i), 4'(i)};
      host.wr_reg(ADDR_THR_WR, d);
      exp_thr[13:12] = d[13:12];
      if (d[11:8] <= 4'hB) exp_thr[11:8] = d[11:8];
      if (d[7:4] <= 4'hB) exp_thr[7:4] = d[7:4];
      if (d[3:0] <= 4'hB) exp_thr[3:0] = d[3:0];
      rd_chk(ADDR_THR_RD, exp_thr);
      check({2'h0, ls_filter_sel_out, ls_vth_u_out, ls_vth_v_out,
             ls_vth_w_out}, exp_thr);
    end
    host.wr_reg(ADDR_THR_RD, 16'h0000);
    rd_chk(ADDR_THR_RD, exp_thr);
    rd_chk(ADDR_THR_WR, 16'h0000);
    rd_chk(8'h55, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      host.wr_reg(ADDR_MASK_WR, 16'hF000 | (16'h0001 << i));
      rd_chk(ADDR_MASK_RD, 16'h0001 << i);
      check({4'h0, det_disable_out}, 16'h0001 << i);
    end
    host.wr_reg(ADDR_MASK_RD, 16'h0000);
    rd_chk(ADDR_MASK_RD, 16'h0800);
    host.wr_reg(ADDR_MASK_WR, 16'h0000);
    cmp_raw_in = 12'hEEE;
    tick(5);
    check({4'h0, det_out}, 16'h0EEE);
    host.wr_reg(ADDR_MASK_WR, 16'h0AAA);
    tick(5);
    check({4'h0, det_out}, 16'h0444);
    host.wr_reg(ADDR_MASK_WR, 16'h0000);
    cmp_raw_in = 12'h000;
    tick(5);
    for (int c = 0; c < 4; c++) filt(2'(c));
    host.wr_reg(ADDR_MASK_WR, 16'h0111);
    cmp_raw_in = 12'h111;
    tick(500);
    check({4'h0, det_out}, 16'h0000);
    cmp_raw_in = 12'h000;
    host.wr_reg(ADDR_MASK_WR, 16'h0000);
    complete_run();
  end
endmodule
